/* File: csq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csq_params.svh"
module csq_sequencer
  import csq_pkg::*;
#(
  parameter int unsigned PRESCALE    = `CSQ_TICK_US * `CSQ_CLK_MHZ,
  parameter int unsigned TPS         = 1000000 / `CSQ_TICK_US,
  parameter int unsigned PRE_TICKS   = `CSQ_PRE_MIN * 60 * TPS,
  parameter int unsigned SAFE_TICKS  = `CSQ_SAFE_HR * 3600 * TPS,
  parameter int unsigned BOOST_TICKS = `CSQ_BOOST_MIN * 60 * TPS
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`CSQ_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Analog front end
  input  wire csq_pkg::csq_sense_s  sense_i,
  output csq_pkg::csq_drive_s       drive_o
);
  import csq_pkg::*;

  localparam int unsigned DET_TICKS = `CSQ_DET_MS * 1000 / `CSQ_TICK_US;

  // ========================================================================
  // Input qualification and tick
  csq_sense_s             sy;
  logic [`CSQ_PRESC_W-1:0] presc_ff;
  logic                   tick;

  csq_sync #(
    .W ($bits(csq_sense_s))
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sense_i),
    .q_o   (sy)
  );

  assign tick = (presc_ff == `CSQ_PRESC_W'(PRESCALE - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  // ========================================================================
  // Registers
  logic [`CSQ_PCT_W-1:0] term_pct_ff;
  logic                  ack_ff;
  logic [31:0]           rdat_ff;
  logic                  wb_req;
  csq_state_e            state_ff;
  logic                  termination_timer_disable_mode_ff;
  logic                  tslow_ff;
  logic                  tout_seen_ff;

  assign wb_req   = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_pct_ff <= `CSQ_CTRL_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `CSQ_ADR_CTRL) begin
      term_pct_ff <= wb_dat_i[`CSQ_PCT_W-1:0];
    end
  end

  // Unmapped reads still ack, with zero data, so software never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `CSQ_ADR_CTRL: rdat_ff <= {26'h0, term_pct_ff};
        `CSQ_ADR_STAT: rdat_ff <= {24'h0, tout_seen_ff, termination_timer_disable_mode_ff,
                                   drive_o.chg_on, drive_o.term_boost,
                                   state_ff};
        default:       rdat_ff <= '0;
      endcase
    end else begin
      rdat_ff <= '0;
    end
  end

  // ========================================================================
  // Conditions
  logic hold;
  logic tfault;
  logic termination_timer_disable_mode;
  logic termination_timer_disable_mode_chg;
  logic quiet;
  logic slow;
  logic in_chg;
  logic chg_ff;
  logic det_rst_ff;
  logic det_term_ff;
  logic pre_exp;
  logic safe_exp;
  logic boost_exp;
  logic det_exp;
  logic term_hit;
  logic safe_clr;
  csq_state_e entry;

  assign hold     = sy.sleep || sy.input_overvoltage_guard;
  assign tfault   = sy.ts_hot || sy.ts_cold;
  assign termination_timer_disable_mode     = sy.ts_high && !sy.ts_low;
  assign termination_timer_disable_mode_chg = termination_timer_disable_mode != termination_timer_disable_mode_ff;
  assign slow     = sy.thermal_reg || sy.foldback;
  assign in_chg   = state_ff inside {ST_PRE, ST_FAST, ST_CV};
  assign entry    = sy.bat_low ? ST_PRE : ST_FAST;
  // Nothing of higher priority than the phase logic is pending
  assign quiet    = !sy.input_undervoltage_lockout && state_ff != ST_OFF && !sy.ts_low
                    && !tslow_ff && !termination_timer_disable_mode_chg && !hold;
  // Raised threshold during the first minute catches a full battery fast
  assign term_hit = boost_exp ? sy.at_term : sy.at_term_boost;
  // Held in reset through the mode and on any disable or power loss
  assign safe_clr = (in_chg && !chg_ff) || termination_timer_disable_mode || sy.input_undervoltage_lockout
                    || sy.ts_low || termination_timer_disable_mode_chg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      termination_timer_disable_mode_ff  <= 1'b0;
      tslow_ff <= 1'b0;
      chg_ff   <= 1'b0;
    end else begin
      termination_timer_disable_mode_ff  <= termination_timer_disable_mode;
      tslow_ff <= sy.ts_low;
      chg_ff   <= in_chg;
    end
  end

  // ========================================================================
  // Timers
  csq_timer u_pre (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (state_ff != ST_PRE),
    .run_i   (!hold && !tfault),
    .tick_i  (tick),
    .slow_i  (slow),
    .limit_i (`CSQ_TMR_W'(PRE_TICKS)),
    .exp_o   (pre_exp)
  );

  csq_timer u_safe (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (safe_clr),
    .run_i   (in_chg && !hold && !tfault),
    .tick_i  (tick),
    .slow_i  (slow),
    .limit_i (`CSQ_TMR_W'(SAFE_TICKS)),
    .exp_o   (safe_exp)
  );

  csq_timer u_boost (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (in_chg && !chg_ff),
    .run_i   (in_chg),
    .tick_i  (tick),
    .slow_i  (1'b0),
    .limit_i (`CSQ_TMR_W'(BOOST_TICKS)),
    .exp_o   (boost_exp)
  );

  csq_timer u_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (det_rst_ff || !(state_ff inside {ST_QUAL, ST_DET})),
    .run_i   (1'b1),
    .tick_i  (tick),
    .slow_i  (1'b0),
    .limit_i (`CSQ_TMR_W'(DET_TICKS)),
    .exp_o   (det_exp)
  );

  // ========================================================================
  // Phase sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= ST_OFF;
      det_rst_ff  <= 1'b0;
      det_term_ff <= 1'b0;
    end else begin
      det_rst_ff <= 1'b0;
      if (sy.input_undervoltage_lockout) begin
        state_ff <= ST_OFF;
      end else if (state_ff == ST_OFF) begin
        state_ff <= ST_QUAL;
      end else if (sy.ts_low) begin
        state_ff <= ST_DIS;
      end else if (tslow_ff) begin
        state_ff <= entry;
      end else if (termination_timer_disable_mode_chg) begin
        state_ff    <= ST_DET;
        det_rst_ff  <= 1'b1;
        det_term_ff <= 1'b0;
      end else if (!hold) begin
        unique case (state_ff)
          ST_QUAL: begin
            if (det_exp) begin
              det_term_ff <= 1'b0;
              state_ff    <= (sy.above_rch && !termination_timer_disable_mode) ? ST_DET : entry;
            end
          end
          ST_DET: begin
            if (termination_timer_disable_mode && det_exp) begin
              state_ff <= entry;
            end else if (det_exp && !tfault) begin
              if (sy.bat_found) begin
                state_ff <= det_term_ff ? ST_DONE : entry;
              end else begin
                det_rst_ff  <= 1'b1;
                det_term_ff <= 1'b0;
              end
            end
          end
          ST_PRE: begin
            if (pre_exp) begin
              state_ff <= ST_TOUT;
            end else if (safe_exp && !termination_timer_disable_mode) begin
              state_ff <= ST_TOUT;
            end else if (!sy.bat_low) begin
              state_ff <= ST_FAST;
            end
          end
          ST_FAST: begin
            if (safe_exp && !termination_timer_disable_mode) begin
              state_ff <= ST_TOUT;
            end else if (sy.above_rch) begin
              state_ff <= ST_CV;
            end
          end
          ST_CV: begin
            if (safe_exp && !termination_timer_disable_mode) begin
              state_ff <= ST_TOUT;
            end else if (term_hit && !termination_timer_disable_mode && !tfault) begin
              state_ff    <= ST_DET;
              det_term_ff <= 1'b1;
            end
          end
          ST_DONE: begin
            if (!sy.above_rch) begin
              state_ff <= entry;
            end
          end
          ST_TOUT, ST_DIS, ST_OFF: begin
            state_ff <= state_ff;
          end
        endcase
      end
    end
  end

  // Sticky record of a timeout, cleared only by a fresh cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tout_seen_ff <= 1'b0;
    end else if (state_ff == ST_TOUT) begin
      tout_seen_ff <= 1'b1;
    end else if (in_chg && !chg_ff) begin
      tout_seen_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Power stage commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.out_hiz    <= sy.input_undervoltage_lockout;
      drive_o.chg_on     <= !sy.input_undervoltage_lockout && !hold && !tfault && !sy.ts_low
                            && (in_chg || state_ff == ST_QUAL);
      drive_o.qual       <= !sy.input_undervoltage_lockout && state_ff == ST_QUAL;
      drive_o.pre        <= !sy.input_undervoltage_lockout && state_ff == ST_PRE;
      drive_o.fast       <= !sy.input_undervoltage_lockout && state_ff == ST_FAST;
      drive_o.cv         <= !sy.input_undervoltage_lockout && state_ff == ST_CV;
      drive_o.half       <= !sy.input_undervoltage_lockout && sy.ts_cool && !tfault;
      drive_o.det_run    <= !sy.input_undervoltage_lockout && state_ff == ST_DET;
      drive_o.term_boost <= !sy.input_undervoltage_lockout && in_chg && !boost_exp;
      drive_o.term_pct   <= sy.pgm_open ? `CSQ_TERM_OPEN
                                        : term_pct_ff;
      drive_o.pre_pct    <= sy.pgm_open ? {`CSQ_TERM_OPEN, 1'b0}
                                        : {term_pct_ff, 1'b0};
    end
  end

  // ========================================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_open_pct_ratio: assert property (
    sy.pgm_open |=> drive_o.term_pct == 6'h0A && drive_o.pre_pct == 7'h14)
    else $error("open programming input not at 10/20 percent");

  a_pre_to_fast: assert property (
    (quiet && state_ff == ST_PRE && !pre_exp && !safe_exp && !sy.bat_low)
      |=> state_ff == ST_FAST)
    else $error("pre-charge did not leave at exit threshold");

  a_temp_fault_off: assert property (
    tfault |=> !drive_o.chg_on)
    else $error("charge on during temperature fault");

  a_sense_low_dis: assert property (
    (sy.ts_low && !sy.input_undervoltage_lockout && state_ff != ST_OFF)
      |=> state_ff == ST_DIS ##1 !drive_o.chg_on)
    else $error("sense low did not disable charge");

  a_pre_timeout: assert property (
    (quiet && state_ff == ST_PRE && pre_exp)
      |=> state_ff == ST_TOUT ##1 !drive_o.chg_on)
    else $error("pre-charge timer expiry not handled");

  a_safe_timeout: assert property (
    (quiet && state_ff == ST_FAST && safe_exp && !termination_timer_disable_mode)
      |=> state_ff == ST_TOUT [*2])
    else $error("safety timer expiry did not end charge");

  a_input_undervoltage_lockout_float: assert property (
    sy.input_undervoltage_lockout |=> drive_o.out_hiz && !drive_o.chg_on && state_ff == ST_OFF)
    else $error("outputs not floating below lockout");

  a_sleep_pause: assert property (
    (hold && in_chg && !sy.input_undervoltage_lockout && !sy.ts_low && !termination_timer_disable_mode_chg && !tslow_ff)
      |=> !drive_o.chg_on && $stable(state_ff))
    else $error("sleep or overvoltage did not pause charge");

  a_mode_entry_det: assert property (
    (termination_timer_disable_mode_chg && !sy.input_undervoltage_lockout && state_ff != ST_OFF && !sy.ts_low && !tslow_ff)
      |=> state_ff == ST_DET)
    else $error("mode change did not start detection");

  a_recharge_new: assert property (
    (quiet && state_ff == ST_DONE && !sy.above_rch)
      |=> state_ff inside {ST_PRE, ST_FAST})
    else $error("recharge threshold did not restart charge");

  c_terminated: cover property (state_ff == ST_CV ##[1:1000] state_ff == ST_DONE);
  c_timed_out:  cover property (state_ff == ST_TOUT);
  c_det_repeat: cover property (state_ff == ST_DET && det_rst_ff && !termination_timer_disable_mode_chg);
  c_termination_timer_disable_mode_taper: cover property (termination_timer_disable_mode && state_ff == ST_CV);
endmodule
`default_nettype wire

/* File: csq_params.svh */
`ifndef CSQ_PARAMS_SVH
`define CSQ_PARAMS_SVH

// ==========================================================================
// Clock and tick base
`define CSQ_CLK_MHZ     200
`define CSQ_TICK_US     1000
`define CSQ_PRESC_W     18

// ==========================================================================
// Timer periods in their own units
`define CSQ_PRE_MIN     30
`define CSQ_SAFE_HR     10
`define CSQ_BOOST_MIN   1
`define CSQ_DET_MS      10
`define CSQ_TMR_W       26

// ==========================================================================
// Threshold programming
`define CSQ_PCT_W       6
`define CSQ_TERM_OPEN   6'h0A

// ==========================================================================
// Register map, byte addresses
`define CSQ_ADR_W       8
`define CSQ_ADR_CTRL    8'h00
`define CSQ_ADR_STAT    8'h04
`define CSQ_CTRL_RST    6'h0A

`endif

/* File: csq_pkg.sv */
`default_nettype none
package csq_pkg;

  typedef enum logic [3:0] {
    ST_OFF, ST_QUAL, ST_DET, ST_PRE, ST_FAST, ST_CV, ST_DONE, ST_TOUT, ST_DIS
  } csq_state_e;

  // Qualified comparator and fault levels from the analog front end
  typedef struct packed {
    logic input_undervoltage_lockout;
    logic sleep;
    logic input_overvoltage_guard;
    logic ts_low;
    logic ts_high;
    logic ts_hot;
    logic ts_cold;
    logic ts_cool;
    logic bat_low;
    logic above_rch;
    logic at_term;
    logic at_term_boost;
    logic bat_found;
    logic thermal_reg;
    logic foldback;
    logic pgm_open;
  } csq_sense_s;

  // Commands to the power stage
  typedef struct packed {
    logic       chg_on;
    logic       qual;
    logic       pre;
    logic       fast;
    logic       half;
    logic       cv;
    logic       out_hiz;
    logic       det_run;
    logic       term_boost;
    logic [5:0] term_pct;
    logic [6:0] pre_pct;
  } csq_drive_s;

endpackage
`default_nettype wire

/* File: csq_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module csq_sync #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  // Stages are cleared so that no unknown reaches the agreement logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit moves only once two stages agree, so a one-cycle glitch is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= (q_ff & (s2_ff ^ s3_ff)) | (s2_ff & ~(s2_ff ^ s3_ff));
    end
  end

  assign q_o = q_ff;
endmodule
`default_nettype wire

/* File: csq_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csq_params.svh"
module csq_timer (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Control
  input  wire logic                  clr_i,
  input  wire logic                  run_i,
  input  wire logic                  tick_i,
  input  wire logic                  slow_i,
  input  wire logic [`CSQ_TMR_W-1:0] limit_i,
  // Status
  output logic                       exp_o
);
  logic [`CSQ_TMR_W-1:0] cnt_ff;
  logic                  half_ff;

  assign exp_o = (cnt_ff >= limit_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      cnt_ff  <= '0;
      half_ff <= 1'b0;
    end else if (run_i && tick_i && !exp_o) begin
      half_ff <= slow_i ? ~half_ff : 1'b0;
      if (!slow_i || half_ff) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_half_rate_skip: assert property (
    (!clr_i && run_i && tick_i && slow_i && !half_ff && !exp_o)
      |=> $stable(cnt_ff) ##0 half_ff)
    else $error("slow timer advanced on a skipped tick");
endmodule
`default_nettype wire

/* File: csq_pack_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Cell, thermistor and supply seen from the charger
module csq_pack_model (
  // Clock
  input  wire logic                clk_i,
  // Charger commands and environment levels
  input  wire csq_pkg::csq_drive_s drive_i,
  input  wire csq_pkg::csq_sense_s env_i,
  // Cell control
  input  wire logic                load_i,
  input  wire logic [7:0]          level_i,
  input  wire logic                hold_i,
  input  wire logic                present_i,
  // Levels to the charger
  output csq_pkg::csq_sense_s      sense_o
);
  import csq_pkg::*;
  localparam logic [7:0] LOWV_LVL  = 8'h14;
  localparam logic [7:0] RCH_LVL   = 8'h3C;
  localparam logic [7:0] BOOST_LVL = 8'h55;
  localparam logic [7:0] TERM_LVL  = 8'h5A;
  localparam logic [7:0] FULL_LVL  = 8'h64;
  logic [7:0] level_ff;

  // Hold freezes the cell so that a timer can run out in one phase
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      level_ff <= level_i;
    // Qualification current is too small to move the cell
    end else if (!hold_i && drive_i.chg_on && !drive_i.qual
                 && level_ff < FULL_LVL) begin
      level_ff <= level_ff + 8'h01;
    end
  end

  always_comb begin
    sense_o = env_i;
    sense_o.bat_low = level_ff < LOWV_LVL;
    sense_o.above_rch = level_ff >= RCH_LVL;
    // Current tapers only while the voltage loop holds the cell
    sense_o.at_term = drive_i.cv && level_ff >= TERM_LVL;
    sense_o.at_term_boost = drive_i.cv && level_ff >= BOOST_LVL;
    sense_o.bat_found = present_i;
  end
endmodule
`default_nettype wire

/* File: charge_cycle_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csq_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module charge_cycle_sequencer_tb;
  import csq_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  csq_sense_s  env;
  csq_sense_s  sense;
  csq_drive_s  drv;
  logic        load;
  logic        hold;
  logic        present;
  logic [7:0]  level;
  logic [31:0] rd;
  int          miscompares;
  int          comparisons;
  int          cycles;

  // ========================================================================
  // Design and partner
  csq_sequencer #(.PRESCALE(4), .PRE_TICKS(20), .SAFE_TICKS(50),
    .BOOST_TICKS(10)) csq_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .sense_i(sense), .drive_o(drv));
  csq_pack_model csq_pack_model_inst (
    .clk_i(clk_i), .drive_i(drv), .env_i(env), .load_i(load),
    .level_i(level), .hold_i(hold), .present_i(present), .sense_o(sense));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial cycles = 0;
  always @(posedge clk_i) cycles <= cycles + 1;

  // ========================================================================
  // Bus and check tasks
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, input logic [3:0] s,
                         output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w;
    wb_adr <= a; wb_wdat <= d; wb_sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      $display("ERROR %0t: bus answer missing", $time);
    end
  endtask

  task automatic wait_state(input logic [3:0] st, input int lim);
    logic [31:0] q;
    int          n;
    n = 0;
    do begin
      wb_xfer(1'b0, `CSQ_ADR_STAT, 32'h0, 4'hF, q);
      n++;
    end while (q[3:0] !== st && n < lim);
    `CHK(q[3:0], st)
  endtask

  task automatic settle();
    repeat (10) @(posedge clk_i);
  endtask

  // Phase must end in timeout after a span of lo..hi cycles
  task automatic timeout_span(input int lo, input int hi);
    int t0;
    t0 = cycles;
    wait_state(4'h7, 300);
    `CHK((cycles - t0) >= lo && (cycles - t0) <= hi, 1'b1)
    `CHK(drv.chg_on, 1'b0)
  endtask

  task automatic report_and_stop();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ========================================================================
  // Scenarios
  initial begin
    miscompares = 0; comparisons = 0;
    env = '0; env.input_undervoltage_lockout = 1'b1; env.pgm_open = 1'b1;
    wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00;
    wb_sel = 4'h0; wb_wdat = 32'h0;
    load = 1'b1; level = 8'h05; hold = 1'b0; present = 1'b1; rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0; load <= 1'b0;
    settle();
    `CHK(drv.out_hiz, 1'b1)
    `CHK(drv.chg_on, 1'b0)
    wb_xfer(1'b0, `CSQ_ADR_CTRL, 32'h0, 4'hF, rd);
    `CHK(rd, 32'h0000000A)
    // Unmapped read still answers, with zero
    wb_xfer(1'b0, 8'h08, 32'h0, 4'hF, rd);
    `CHK(rd, 32'h00000000)
    @(posedge clk_i); env.input_undervoltage_lockout <= 1'b0;
    wait_state(4'h1, 20);
    `CHK(drv.qual, 1'b1)
    wait_state(4'h3, 30);
    `CHK(drv.term_pct, 6'h0A)
    `CHK(drv.pre_pct, 7'h14)
    wait_state(4'h4, 30);
    hold <= 1'b1;
    env.ts_cool <= 1'b1;
    settle();
    `CHK(drv.half, 1'b1)
    env.ts_cool <= 1'b0;
    // Sleep, overvoltage, hot, cold: each stops current while it lasts
    for (int b = 9; b <= 14; b++) begin
      if (b == 11 || b == 12) continue;
      env[b] <= 1'b1;
      settle();
      `CHK(drv.chg_on, 1'b0)
      env[b] <= 1'b0;
      settle();
      `CHK(drv.chg_on, 1'b1)
    end
    present <= 1'b0; hold <= 1'b0;
    wait_state(4'h2, 80);
    repeat (100) @(posedge clk_i);
    wait_state(4'h2, 1);
    `CHK(drv.det_run, 1'b1)
    // Insertion starts a fresh cycle, which the raised threshold ends
    present <= 1'b1;
    wait_state(4'h6, 60);
    `CHK(drv.chg_on, 1'b0)
    load <= 1'b1; level <= 8'h28; hold <= 1'b1;
    @(posedge clk_i); load <= 1'b0;
    wait_state(4'h4, 30);
    wb_xfer(1'b0, `CSQ_ADR_STAT, 32'h0, 4'hF, rd);
    `CHK(rd[4], 1'b1)
    timeout_span(170, 240);
    env.thermal_reg <= 1'b1;
    env.ts_low <= 1'b1;
    wait_state(4'h8, 20);
    `CHK(drv.chg_on, 1'b0)
    env.ts_low <= 1'b0;
    wait_state(4'h4, 40);
    timeout_span(360, 480);
    env.thermal_reg <= 1'b0; env.input_undervoltage_lockout <= 1'b1;
    load <= 1'b1; level <= 8'h05;
    settle();
    load <= 1'b0; env.input_undervoltage_lockout <= 1'b0;
    wait_state(4'h3, 30);
    timeout_span(60, 120);
    load <= 1'b1; level <= 8'h5F; hold <= 1'b0;
    env.ts_high <= 1'b1;
    @(posedge clk_i); load <= 1'b0;
    wait_state(4'h5, 60);
    wb_xfer(1'b0, `CSQ_ADR_STAT, 32'h0, 4'hF, rd);
    `CHK(rd[6], 1'b1)
    repeat (300) @(posedge clk_i);
    wait_state(4'h5, 1);
    env.ts_high <= 1'b0;
    wait_state(4'h6, 100);
    env.pgm_open <= 1'b0;
    wb_xfer(1'b1, `CSQ_ADR_CTRL, 32'h0000000C, 4'h1, rd);
    // Write with no byte enabled must be dropped
    wb_xfer(1'b1, `CSQ_ADR_CTRL, 32'h00000005, 4'h0, rd);
    settle();
    `CHK(drv.term_pct, 6'h0C)
    `CHK(drv.pre_pct, 7'h18)
    wb_xfer(1'b0, `CSQ_ADR_CTRL, 32'h0, 4'hF, rd);
    `CHK(rd, 32'h0000000C)
    report_and_stop();
  end
endmodule
`default_nettype wire
